// ===== hw/gfc_cmd_ctrl.sv
// command interpreter for continuous measurement, concentration update, stop and averaging
// Function
// [RULE_01] concentration instruction accepted while measurement runs
// [RULE_02] pointer reset restores normal result buffer
// [RULE_03] measurement continues with new concentration, no restart
// [RULE_04] host sends at most one update per millisecond
// [RULE_05] concentration above 1000 stops measurement
// [RULE_06] start command concentration applies immediately
// [RULE_07] new start command costs 12 ms
// [RULE_08] host issues no read during update
// [RULE_09] stop ends measurement, idle within 0.5 ms
// [RULE_10] only stop and update accepted while measuring
// [RULE_11] averaging count zero means read-triggered mode
// [RULE_12] count one to 128 averages fixed samples
// [RULE_13] averaging persists until rewritten or reset
// [RULE_14] averaging count above 128 clamped to 128
// [RULE_15] host uses count one for unaveraged flow
// [RULE_16] read without available result is not acknowledged
// [RULE_17] read returns flow, temperature, status, each with crc
// [RULE_18] status bit 10 shows averaging mode
// [RULE_19] every command argument carries its crc byte
// [RULE_20] codes and arguments sent msb first
module gfc_cmd_ctrl #(
    parameter int unsigned START_CYCLES = gfc_pkg::START_CYC,
    parameter int unsigned STOP_CYCLES  = gfc_pkg::STOP_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic        wrStart,        // address with write bit acknowledged
    input  wire logic        wrByteValid,
    input  wire logic [7:0]  wrByte,
    input  wire logic        wrStop,         // end of the write transaction
    input  wire logic        rdHeader,       // address with read bit seen
    output logic             rdAck,
    input  wire logic        rdNext,         // host acknowledged, next byte wanted
    output logic [7:0]       rdByte,
    input  wire logic        sampleValid,
    input  wire logic [15:0] flowSample,
    input  wire logic [15:0] tempSample,
    output logic             measureOn,      // heater on, measurement running
    output logic             idleMode,
    output logic [3:0]       gasSel,
    output logic [9:0]       concentration,
    output logic [7:0]       avgCount,
    output logic             cmdReject
);

    typedef struct packed {
        gfc_pkg::gfc_state_t              state;
        logic [gfc_pkg::TMR_W-1:0]        timer;
        logic [2:0]                       wrCnt;
        logic                             wrOvf;
        logic [15:0]                      cmd;
        logic [15:0]                      arg;
        logic [7:0]                       crc;
        logic [3:0]                       gas;
        logic [9:0]                       conc;
        logic [9:0]                       pendConc;
        logic                             pendValid;
        logic                             ptrNormal;
        logic [7:0]                       avgN;
        logic [8:0][7:0]                  rdBuf;
        logic [3:0]                       rdIdx;
        logic [7:0]                       rdByte;
        logic                             reject;
    } gfc_ctrl_st_t;

    gfc_ctrl_st_t s_r;
    gfc_ctrl_st_t s_nxt;
    gfc_avg_if    avgBus ();

    logic         isStart;
    logic         isMix;
    logic [3:0]   startGas;
    logic         needArg;
    logic         argOk;
    logic         execCmd;
    logic [15:0]  statusWord;

    ////////////////////////////////////////////////////////////////////////////////
    // crc over one 16-bit word, shared by argument check and read data
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = gfc_pkg::CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ gfc_pkg::CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // decode of the received command code
    always_comb begin
        isStart  = 1'b1;
        isMix    = 1'b0;
        startGas = 4'h0;
        case (s_r.cmd)
            gfc_pkg::CMD_START_G0:  startGas = 4'h0;
            gfc_pkg::CMD_START_G1:  startGas = 4'h1;
            gfc_pkg::CMD_START_G2:  startGas = 4'h2;
            gfc_pkg::CMD_START_G3:  startGas = 4'h3;
            gfc_pkg::CMD_START_R4:  startGas = 4'h4;
            gfc_pkg::CMD_START_R5:  startGas = 4'h5;
            gfc_pkg::CMD_START_MX0: begin
                startGas = 4'h6;
                isMix    = 1'b1;
            end
            gfc_pkg::CMD_START_MX1: begin
                startGas = 4'h7;
                isMix    = 1'b1;
            end
            gfc_pkg::CMD_START_MX2: begin
                startGas = 4'h8;
                isMix    = 1'b1;
            end
            default:                isStart = 1'b0;
        endcase
    end

    // argument commands need code, argument and a matching crc, nothing more
    assign needArg = isMix || s_r.cmd == gfc_pkg::CMD_TX_CONC || s_r.cmd == gfc_pkg::CMD_AVG_CFG;
    assign argOk   = !s_r.wrOvf && s_r.wrCnt == gfc_pkg::WR_ARG_LEN
                     && crc8(s_r.arg) == s_r.crc;                            // [RULE_19]
    assign execCmd = wrStop && s_r.wrCnt >= 3'h2;

    // status word: running command, smoothing flag, averaging mode, concentration
    always_comb begin
        statusWord = {6'h00, s_r.conc};
        statusWord[gfc_pkg::ST_GAS_LSB +: 4] = s_r.gas;
        statusWord[gfc_pkg::ST_SMTH_BIT]     = 1'b0;
        statusWord[gfc_pkg::ST_AVG_BIT]      = s_r.avgN != 8'h00;            // [RULE_18]
    end

    // a read header is answered only when the pointer is on a ready result
    assign rdAck = rdHeader && s_r.state == gfc_pkg::GFC_MEAS && s_r.ptrNormal
                   && avgBus.resultValid;                                    // [RULE_16]

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt        = s_r;
        s_nxt.reject = 1'b0;
        // write byte capture, msb of code first, then argument and crc
        if (wrStart) begin
            s_nxt.wrCnt = 3'h0;
            s_nxt.wrOvf = 1'b0;
        end else if (wrByteValid) begin
            case (s_r.wrCnt)
                3'h0:    s_nxt.cmd[15:8] = wrByte;                          // [RULE_20]
                3'h1:    s_nxt.cmd[7:0]  = wrByte;
                3'h2:    s_nxt.arg[15:8] = wrByte;                          // [RULE_20]
                3'h3:    s_nxt.arg[7:0]  = wrByte;
                3'h4:    s_nxt.crc       = wrByte;
                default: s_nxt.wrOvf     = 1'b1;
            endcase
            if (s_r.wrCnt < gfc_pkg::WR_ARG_LEN) begin
                s_nxt.wrCnt = s_r.wrCnt + 3'h1;
            end
        end
        if (wrStop) begin
            s_nxt.wrCnt = 3'h0;
        end

        // countdowns of start-up and heater power-down
        case (s_r.state)
            gfc_pkg::GFC_STARTING: begin
                if (s_r.timer == '0) begin
                    s_nxt.state     = gfc_pkg::GFC_MEAS;                    // [RULE_07]
                    s_nxt.ptrNormal = 1'b1;
                end else begin
                    s_nxt.timer = s_r.timer - 1'b1;
                end
            end
            gfc_pkg::GFC_STOPPING: begin
                if (s_r.timer == '0) begin
                    s_nxt.state = gfc_pkg::GFC_IDLE;                        // [RULE_09]
                end else begin
                    s_nxt.timer = s_r.timer - 1'b1;
                end
            end
            default: ;
        endcase

        // command execution at the end of the write
        if (execCmd) begin
            if (needArg && !argOk) begin
                s_nxt.reject = 1'b1;
            end else if (s_r.state == gfc_pkg::GFC_STOPPING) begin
                s_nxt.reject = 1'b1;                // still powering down
            end else if (s_r.state == gfc_pkg::GFC_IDLE) begin
                if (isStart) begin
                    s_nxt.state     = gfc_pkg::GFC_STARTING;                // [RULE_07]
                    s_nxt.timer     = gfc_pkg::TMR_W'(START_CYCLES - 1);
                    s_nxt.gas       = startGas;
                    s_nxt.conc      = isMix ? s_r.arg[9:0] : gfc_pkg::CONC_PURE; // [RULE_06]
                    s_nxt.pendValid = 1'b0;
                    s_nxt.ptrNormal = 1'b0;
                end else if (s_r.cmd == gfc_pkg::CMD_AVG_CFG) begin
                    s_nxt.avgN = (s_r.arg > gfc_pkg::AVG_N_MAX)
                                 ? gfc_pkg::AVG_N_MAX[7:0] : s_r.arg[7:0]; // [RULE_14]
                end else if (s_r.cmd != gfc_pkg::CMD_STOP) begin
                    s_nxt.reject = 1'b1;
                end
            end else begin
                // measuring or starting: only stop and the update pair get through
                if (s_r.cmd == gfc_pkg::CMD_STOP) begin
                    s_nxt.state = gfc_pkg::GFC_STOPPING;                    // [RULE_09]
                    s_nxt.timer = gfc_pkg::TMR_W'(STOP_CYCLES - 1);
                end else if (s_r.cmd == gfc_pkg::CMD_TX_CONC) begin
                    if (s_r.arg > gfc_pkg::CONC_MAX) begin
                        s_nxt.state = gfc_pkg::GFC_STOPPING;                // [RULE_05]
                        s_nxt.timer = gfc_pkg::TMR_W'(STOP_CYCLES - 1);
                    end else begin
                        s_nxt.pendConc  = s_r.arg[9:0];                     // [RULE_01]
                        s_nxt.pendValid = 1'b1;
                        s_nxt.ptrNormal = 1'b0;     // pointer leaves the result buffer
                    end
                end else if (s_r.cmd == gfc_pkg::CMD_PTR_RST) begin
                    s_nxt.ptrNormal = s_r.state == gfc_pkg::GFC_MEAS
                                      || s_r.ptrNormal;                     // [RULE_02]
                    if (s_r.pendValid) begin
                        s_nxt.conc      = s_r.pendConc;                     // [RULE_03]
                        s_nxt.pendValid = 1'b0;
                    end
                end else begin
                    s_nxt.reject = 1'b1;                                    // [RULE_10]
                end
            end
        end

        // read data: snapshot on the acknowledged header, then one byte per request
        if (rdAck) begin
            s_nxt.rdBuf[0] = avgBus.flowRes[15:8];                          // [RULE_17]
            s_nxt.rdBuf[1] = avgBus.flowRes[7:0];
            s_nxt.rdBuf[2] = crc8(avgBus.flowRes);
            s_nxt.rdBuf[3] = avgBus.tempRes[15:8];
            s_nxt.rdBuf[4] = avgBus.tempRes[7:0];
            s_nxt.rdBuf[5] = crc8(avgBus.tempRes);
            s_nxt.rdBuf[6] = statusWord[15:8];
            s_nxt.rdBuf[7] = statusWord[7:0];
            s_nxt.rdBuf[8] = crc8(statusWord);
            s_nxt.rdByte   = avgBus.flowRes[15:8];
            s_nxt.rdIdx    = 4'h1;
        end else if (rdNext) begin
            // an early nack simply leaves the rest unread
            s_nxt.rdByte = (s_r.rdIdx < gfc_pkg::RD_BYTES) ? s_r.rdBuf[s_r.rdIdx]
                                                           : gfc_pkg::RD_FILL; // [RULE_17]
            if (s_r.rdIdx < gfc_pkg::RD_BYTES) begin
                s_nxt.rdIdx = s_r.rdIdx + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register; averaging count returns to read-triggered mode on reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_r       <= '0;
            s_r.state <= gfc_pkg::GFC_IDLE;
            s_r.conc  <= gfc_pkg::CONC_RST;
            s_r.avgN  <= gfc_pkg::AVG_N_RST;                                // [RULE_13]
        end else if (clkEn) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // averaging unit; samples count only while results are being produced
    assign avgBus.avgN        = s_r.avgN;                                   // [RULE_13]
    assign avgBus.clear       = s_r.state != gfc_pkg::GFC_MEAS;
    assign avgBus.sampleValid = sampleValid && s_r.state == gfc_pkg::GFC_MEAS; // [RULE_03]
    assign avgBus.flowSample  = flowSample;
    assign avgBus.tempSample  = tempSample;
    assign avgBus.consume     = rdAck;                                      // [RULE_11]

    gfc_avg_unit u_avg (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .port    (avgBus.avg)
    );

    // outputs, all from registers
    assign rdByte        = s_r.rdByte;
    assign measureOn     = s_r.state == gfc_pkg::GFC_STARTING || s_r.state == gfc_pkg::GFC_MEAS;
    assign idleMode      = s_r.state == gfc_pkg::GFC_IDLE;
    assign gasSel        = s_r.gas;
    assign concentration = s_r.conc;
    assign avgCount      = s_r.avgN;
    assign cmdReject     = s_r.reject;

endmodule // gfc_cmd_ctrl

// ===== hw/gfc_pkg.sv
// shared constants, command codes and state encoding for the gas flow command control
package gfc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_KHZ     = 50000;      // clk_sys rate in kHz
    localparam int unsigned START_MS    = 12;         // start command to first result
    localparam int unsigned STOP_US     = 500;        // stop command to idle, at most
    localparam int unsigned START_CYC   = START_MS * CLK_KHZ;
    localparam int unsigned STOP_CYC    = (STOP_US * CLK_KHZ) / 1000;  // longest time, rounded down
    localparam int unsigned TMR_W       = 24;

    ////////////////////////////////////////////////////////////////////////////////
    // command codes, sent most significant byte first
    localparam logic [15:0] CMD_TX_CONC   = 16'he17d;
    localparam logic [15:0] CMD_PTR_RST   = 16'he000;
    localparam logic [15:0] CMD_STOP      = 16'h3ff9;
    localparam logic [15:0] CMD_AVG_CFG   = 16'h366a;
    localparam logic [15:0] CMD_START_G0  = 16'h3603;
    localparam logic [15:0] CMD_START_G1  = 16'h3608;
    localparam logic [15:0] CMD_START_G2  = 16'h3615;
    localparam logic [15:0] CMD_START_G3  = 16'h361e;
    localparam logic [15:0] CMD_START_R4  = 16'h3624;
    localparam logic [15:0] CMD_START_R5  = 16'h362f;
    localparam logic [15:0] CMD_START_MX0 = 16'h3632;
    localparam logic [15:0] CMD_START_MX1 = 16'h3639;
    localparam logic [15:0] CMD_START_MX2 = 16'h3646;

    ////////////////////////////////////////////////////////////////////////////////
    // arguments, limits and reset values
    localparam logic [15:0] CONC_MAX    = 16'h03e8;   // 1000 per mille
    localparam logic [15:0] AVG_N_MAX   = 16'h0080;   // 128 samples
    localparam logic [7:0]  AVG_N_RST   = 8'h00;      // read-triggered averaging
    localparam logic [9:0]  CONC_PURE   = 10'h3ff;    // pure gas marker
    localparam logic [9:0]  CONC_RST    = 10'h3ff;
    localparam logic [7:0]  CRC_POLY    = 8'h31;
    localparam logic [7:0]  CRC_INIT    = 8'hff;
    localparam logic [7:0]  RD_FILL     = 8'hff;      // byte beyond the last one
    localparam logic [3:0]  RD_BYTES    = 4'h9;
    localparam logic [2:0]  WR_ARG_LEN  = 3'h5;       // code, argument, crc

    ////////////////////////////////////////////////////////////////////////////////
    // status word layout
    localparam int unsigned ST_GAS_LSB  = 12;
    localparam int unsigned ST_SMTH_BIT = 11;
    localparam int unsigned ST_AVG_BIT  = 10;

    typedef enum logic [2:0] {
        GFC_IDLE     = 3'b000,
        GFC_STARTING = 3'b001,
        GFC_MEAS     = 3'b010,
        GFC_STOPPING = 3'b011
    } gfc_state_t;

endpackage : gfc_pkg

// ===== hw/gfc_avg_if.sv
// carrier between the command control and the flow averaging unit
interface gfc_avg_if;
    logic [7:0]  avgN;
    logic        clear;
    logic        sampleValid;
    logic [15:0] flowSample;
    logic [15:0] tempSample;
    logic        consume;
    logic        resultValid;
    logic [15:0] flowRes;
    logic [15:0] tempRes;

    modport ctrl (output avgN, clear, sampleValid, flowSample, tempSample, consume,
                  input resultValid, flowRes, tempRes);
    modport avg  (input avgN, clear, sampleValid, flowSample, tempSample, consume,
                  output resultValid, flowRes, tempRes);
endinterface : gfc_avg_if

// ===== hw/gfc_avg_unit.sv
// flow averaging unit: read-triggered or fixed sample count
module gfc_avg_unit (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic clkEn,
    gfc_avg_if.avg    port
);

    typedef struct packed {
        logic signed [23:0] sum;
        logic [7:0]         cnt;
        logic [15:0]        flowRes;
        logic [15:0]        tempRes;
        logic               valid;
    } gfc_avg_st_t;

    gfc_avg_st_t        a_r;
    gfc_avg_st_t        a_nxt;
    logic signed [23:0] sumIn;
    logic [7:0]         cntIn;
    logic signed [23:0] sumAdd;
    logic [7:0]         cntAdd;
    logic signed [23:0] divisor;

    ////////////////////////////////////////////////////////////////////////////////
    // a read empties the window in read-triggered mode; the sample of that cycle opens the next
    always_comb begin
        a_nxt   = a_r;
        sumIn   = a_r.sum;
        cntIn   = a_r.cnt;
        if (port.consume && port.avgN == 8'h00) begin
            sumIn = '0;
            cntIn = 8'h00;
        end
        sumAdd  = sumIn + {{8{port.flowSample[15]}}, port.flowSample};
        cntAdd  = cntIn + 8'h01;
        divisor = (port.avgN == 8'h00) ? {16'h0000, cntAdd} : {16'h0000, port.avgN};
        a_nxt.sum = sumIn;
        a_nxt.cnt = cntIn;
        if (port.clear) begin
            a_nxt = '0;
        end else if (port.sampleValid) begin
            a_nxt.tempRes = port.tempSample;
            if (port.avgN == 8'h00) begin
                // window saturates at 255 samples: later flow samples are dropped until the next read
                if (cntIn != 8'hff) begin
                    a_nxt.sum     = sumAdd;
                    a_nxt.cnt     = cntAdd;
                    a_nxt.flowRes = 16'(sumAdd / divisor);  // [RULE_11]
                    a_nxt.valid   = 1'b1;
                end
            end else if (cntAdd == port.avgN) begin
                a_nxt.sum     = '0;                       // [RULE_12]
                a_nxt.cnt     = 8'h00;
                a_nxt.flowRes = 16'(sumAdd / divisor);    // [RULE_12]
                a_nxt.valid   = 1'b1;
            end else begin
                a_nxt.sum = sumAdd;
                a_nxt.cnt = cntAdd;
            end
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            a_r <= '0;
        end else if (clkEn) begin
            a_r <= a_nxt;
        end
    end

    assign port.resultValid = a_r.valid;
    assign port.flowRes     = a_r.flowRes;
    assign port.tempRes     = a_r.tempRes;

endmodule // gfc_avg_unit

// ===== tb/gfc_cmd_ctrl_properties.sv
// port assertions
module gfc_cmd_ctrl_properties #(
    parameter int unsigned STOP_CYCLES = 10
) (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       wrStop,
    input wire logic       rdHeader,
    input wire logic       rdAck,
    input wire logic       measureOn,
    input wire logic       idleMode,
    input wire logic [3:0] gasSel,
    input wire logic [9:0] concentration,
    input wire logic [7:0] avgCount,
    input wire logic       cmdReject
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STOP_LIM = STOP_CYCLES + 2;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    property p_ack; rdHeader && rdAck |-> measureOn && !idleMode; endproperty
    a_ack: assert property (p_ack) else $error("ack while off");
    property p_warm; $rose(measureOn) |-> (!(rdHeader && rdAck)) [*8]; endproperty
    a_warm: assert property (p_warm) else $error("early ack");
    property p_rej; cmdReject |-> $past(wrStop); endproperty
    a_rej: assert property (p_rej) else $error("stray refusal");
    property p_stop; $fell(measureOn) |-> ##[0:STOP_LIM] idleMode; endproperty
    a_stop: assert property (p_stop) else $error("idle too late");
    property p_avgh; !$stable(avgCount) |-> $past(wrStop) && $past(idleMode); endproperty
    a_avgh: assert property (p_avgh) else $error("averaging moved");
    property p_avgm; avgCount <= 8'h80; endproperty
    a_avgm: assert property (p_avgm) else $error("averaging over 128");
    property p_conc; concentration <= 10'h3e8 || concentration == 10'h3ff; endproperty
    a_conc: assert property (p_conc) else $error("bad concentration");
    property p_gas; !$stable(gasSel) || !$stable(concentration) |-> $past(wrStop); endproperty
    a_gas: assert property (p_gas) else $error("gas moved");
    c_ack: cover property (rdHeader && rdAck);
    c_rej: cover property (cmdReject);
    c_stop: cover property ($fell(measureOn));
endmodule // gfc_cmd_ctrl_properties

bind gfc_cmd_ctrl gfc_cmd_ctrl_properties #(.STOP_CYCLES(STOP_CYCLES))
    gfc_cmd_ctrl_properties_inst (.clk_sys, .rst_n, .wrStop, .rdHeader, .rdAck, .measureOn,
    .idleMode, .gasSel, .concentration, .avgCount, .cmdReject);

// ===== tb/gfc_host.sv
// host model
module gfc_host (
    input  wire logic       clk_sys,
    input  wire logic       rdAck,
    input  wire logic [7:0] rdByte,
    output logic            wrStart,
    output logic            wrByteValid,
    output logic [7:0]      wrByte,
    output logic            wrStop,
    output logic            rdHeader,
    output logic            rdNext
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wrStart, wrByteValid, wrByte, wrStop, rdHeader, rdNext} = '0;
    ////////////////////////////////////////////////////////////
    // crc-8, msb first
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] k;
        k = 8'hff;
        for (int i = 15; i >= 0; i--) begin
            k = {k[6:0], 1'b0} ^ ((k[7] ^ d[i]) ? 8'h31 : 8'h00);
        end
        return k;
    endfunction
    // bad corrupts the crc
    task automatic cmd(input logic [15:0] code, arg, input bit hasArg, bad);
        logic [7:0] b [5];
        b = '{code[15:8], code[7:0], arg[15:8], arg[7:0], crc8(arg) ^ {7'h00, bad}};
        @(posedge clk_sys) wrStart <= 1'b1;
        for (int i = 0; i < (hasArg ? 5 : 2); i++) begin
            @(posedge clk_sys) {wrStart, wrByteValid, wrByte} <= {2'b01, b[i]};
        end
        // released data inverts
        @(posedge clk_sys) {wrByteValid, wrByte, wrStop} <= {1'b0, ~wrByte, 1'b1};
        @(posedge clk_sys) wrStop <= 1'b0;
        @(negedge clk_sys);
    endtask
    // header and nine bytes
    task automatic rd(output logic ack, output logic [7:0] b [9]);
        @(posedge clk_sys) rdHeader <= 1'b1;
        @(negedge clk_sys) ack = rdAck;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_sys) {rdHeader, rdNext} <= {1'b0, (i < 8) && ack};
            @(negedge clk_sys) b[i] = rdByte;
        end
        @(posedge clk_sys) rdNext <= 1'b0;
    endtask
endmodule // gfc_host

// ===== tb/gfc_cmd_ctrl_tb.sv
// command control bench
module gfc_cmd_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst_n, clkEn, sampleValid, wrStart, wrByteValid, wrStop;
    logic        rdHeader, rdNext, rdAck, measureOn, idleMode, cmdReject, ack;
    logic [3:0]  gasSel;
    logic [7:0]  wrByte, rdByte, avgCount;
    logic [7:0]  fr [9];
    logic [9:0]  concentration;
    logic [15:0] flowSample, tempSample, c, f;
    logic [15:0] tab [5];
    int          miscompares, samples_checked;
    gfc_cmd_ctrl #(.START_CYCLES(20), .STOP_CYCLES(10)) gfc_cmd_ctrl_inst (
        .clk_sys, .rst_n, .clkEn, .wrStart, .wrByteValid, .wrByte, .wrStop, .rdHeader,
        .rdAck, .rdNext, .rdByte, .sampleValid, .flowSample, .tempSample, .measureOn,
        .idleMode, .gasSel, .concentration, .avgCount, .cmdReject);
    gfc_host gfc_host_inst (.clk_sys, .rdAck, .rdByte, .wrStart, .wrByteValid, .wrByte,
        .wrStop, .rdHeader, .rdNext);
    ////////////////////////////////////////////////////////////
    // status reads run with fixed-count averaging
    function automatic logic [15:0] stat(input logic [3:0] g, input logic [9:0] k);
        return {g, 2'b01, k};
    endfunction
    task automatic chk(input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkF(input logic got, exp);
        chk(16'(got), 16'(exp));
    endtask
    // n=1: last sample is the result
    task automatic feed();
        repeat (3) begin
            f = 16'($urandom);
            @(posedge clk_sys) {sampleValid, flowSample, tempSample} <= {1'b1, f, 16'($urandom)};
        end
        @(posedge clk_sys) {sampleValid, flowSample} <= {1'b0, ~f};
    endtask
    task automatic readChk(input logic [15:0] st);
        gfc_host_inst.rd(ack, fr);
        chkF(ack, 1'b1);
        chk({fr[0], fr[1]}, f);
        chk(16'(fr[2]), 16'(gfc_host_inst.crc8(f)));
        chk(16'(fr[5]), 16'(gfc_host_inst.crc8({fr[3], fr[4]})));
        chk({fr[6], fr[7]}, st);
        chk(16'(fr[8]), 16'(gfc_host_inst.crc8(st)));
    endtask
    // bounded wait
    task automatic waitIdle();
        for (int n = 0; n < 14 && idleMode !== 1'b1; n++) begin
            @(negedge clk_sys);
        end
        chkF(idleMode, 1'b1);
        if (idleMode !== 1'b1) begin
            conclude();
        end
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // main sequence
    initial begin
        {rst_n, sampleValid, flowSample, tempSample} = '0;
        clkEn = 1'b1;
        miscompares = 0;
        samples_checked = 0;
        tab = '{16'h012c, 16'h0080, 16'h0000, 16'($urandom(34017)), 16'h0001};
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        chk(16'(avgCount), 16'h0000);
        chk(16'(concentration), 16'h03ff);
        gfc_host_inst.rd(ack, fr);
        chkF(ack, 1'b0);
        $display("done: reset");
        foreach (tab[i]) begin
            gfc_host_inst.cmd(gfc_pkg::CMD_AVG_CFG, tab[i], 1'b1, 1'b0);
            chk(16'(avgCount), (tab[i] > 16'h0080) ? 16'h0080 : tab[i]);
        end
        gfc_host_inst.cmd(gfc_pkg::CMD_AVG_CFG, 16'h0005, 1'b1, 1'b1);
        chkF(cmdReject, 1'b1);
        $display("done: averaging");
        c = 16'($urandom_range(1000));
        gfc_host_inst.cmd(gfc_pkg::CMD_START_MX0, c, 1'b1, 1'b0);
        chk(16'(concentration), c);
        gfc_host_inst.rd(ack, fr);
        chkF(ack, 1'b0);
        repeat (20) @(negedge clk_sys);
        feed();
        readChk(stat(4'h6, c[9:0]));
        gfc_host_inst.cmd(gfc_pkg::CMD_AVG_CFG, 16'h0007, 1'b1, 1'b0);
        chkF(cmdReject, 1'b1);
        chk(16'(avgCount), 16'h0001);
        // update pair, no read between
        gfc_host_inst.cmd(gfc_pkg::CMD_TX_CONC, 16'h03e8, 1'b1, 1'b0);
        chkF(measureOn, 1'b1);
        gfc_host_inst.cmd(gfc_pkg::CMD_PTR_RST, 16'h0000, 1'b0, 1'b0);
        chk(16'(concentration), 16'h03e8);
        feed();
        readChk(stat(4'h6, 10'h3e8));
        repeat (50000) @(posedge clk_sys);
        gfc_host_inst.cmd(gfc_pkg::CMD_TX_CONC, 16'h03e9, 1'b1, 1'b0);
        waitIdle();
        $display("done: update");
        gfc_host_inst.cmd(gfc_pkg::CMD_START_G1, 16'h0000, 1'b0, 1'b0);
        chk(16'(gasSel), 16'h0001);
        gfc_host_inst.cmd(gfc_pkg::CMD_STOP, 16'h0000, 1'b0, 1'b0);
        gfc_host_inst.cmd(gfc_pkg::CMD_AVG_CFG, 16'h0003, 1'b1, 1'b0);
        chkF(cmdReject, 1'b1);
        waitIdle();
        @(posedge clk_sys) rst_n <= 1'b0;
        @(negedge clk_sys);
        chk(16'(avgCount), 16'h0000);
        $display("done: stop");
        conclude();
    end
endmodule // gfc_cmd_ctrl_tb
